/* File: rtl/sfr_pkg.sv */
// constants and types for the discoverable-parameter read block
//
// Overview of operation
// [R01] offsets 00H-03H signature, 04H minor revision 00H
// [R02] offset 05H returns major revision 01H
// [R03] offset 06H returns header count 01H
// [R04] unused bytes 07H, 0FH, 17H read FFH
// [R05] header 0 id 00H, revision 00H/01H
// [R06] offset 0BH returns table length 09H
// [R07] pointer bytes 0CH-0EH read 30H, 00H, 00H
// [R08] header 1 id is maker code, revision 00H/01H
// [R09] header 1 length 03H, pointer 60H, 00H, 00H
// [R10] byte 30H bits 1:0 01b, byte 31H 20H
// [R11] byte 30H bit 2 reads 1b
// [R12] byte 30H bits 3 and 4 read 0b
// [R13] byte 30H bits 7:5 111b, byte E5H
// [R14] dword 1 (bytes 30H-33H) bits 18:17 read 00b
// [R15] byte 32H reads F1H, no double rate
// [R16] byte 38H 44H, byte 39H EBH
// [R17] byte 3AH 08H, byte 3BH 6BH
// [R18] byte 3CH returns 08H
// [R19] host: zero wait states means unsupported
// [R20] host: zero mode bits means unsupported
// [R21] byte 3DH returns opcode 3BH
// [R22] content read-only, every read identical
// [R23] 3-byte offset, then incrementing bytes until deselect
package sfr_pkg;
  // ----------------------------------------------------------------
  // framing
  // ----------------------------------------------------------------
  localparam logic [7:0] SFR_OPC_READ = 8'h5A;
  localparam int SFR_OFS_W = 24;
  localparam logic [1:0] SFR_ADDR_LAST = 2'h2;
  localparam logic [7:0] SFR_FILL = 8'hFF;
  localparam logic [23:0] SFR_OFS_ONE = 24'h000001;
  localparam logic [23:0] SFR_OFS_ZERO = 24'h000000;
  // ----------------------------------------------------------------
  // byte offsets
  // ----------------------------------------------------------------
  localparam logic [23:0] SFR_O_SIG0 = 24'h000000;
  localparam logic [23:0] SFR_O_SIG1 = 24'h000001;
  localparam logic [23:0] SFR_O_SIG2 = 24'h000002;
  localparam logic [23:0] SFR_O_SIG3 = 24'h000003;
  localparam logic [23:0] SFR_O_MINOR = 24'h000004;
  localparam logic [23:0] SFR_O_MAJOR = 24'h000005;
  localparam logic [23:0] SFR_O_NHDR = 24'h000006;
  localparam logic [23:0] SFR_O_PAD0 = 24'h000007;
  localparam logic [23:0] SFR_O_H0ID = 24'h000008;
  localparam logic [23:0] SFR_O_H0MIN = 24'h000009;
  localparam logic [23:0] SFR_O_H0MAJ = 24'h00000A;
  localparam logic [23:0] SFR_O_H0LEN = 24'h00000B;
  localparam logic [23:0] SFR_O_H0P0 = 24'h00000C;
  localparam logic [23:0] SFR_O_H0P1 = 24'h00000D;
  localparam logic [23:0] SFR_O_H0P2 = 24'h00000E;
  localparam logic [23:0] SFR_O_PAD1 = 24'h00000F;
  localparam logic [23:0] SFR_O_H1ID = 24'h000010;
  localparam logic [23:0] SFR_O_H1MIN = 24'h000011;
  localparam logic [23:0] SFR_O_H1MAJ = 24'h000012;
  localparam logic [23:0] SFR_O_H1LEN = 24'h000013;
  localparam logic [23:0] SFR_O_H1P0 = 24'h000014;
  localparam logic [23:0] SFR_O_H1P1 = 24'h000015;
  localparam logic [23:0] SFR_O_H1P2 = 24'h000016;
  localparam logic [23:0] SFR_O_PAD2 = 24'h000017;
  localparam logic [23:0] SFR_O_ERCFG = 24'h000030;
  localparam logic [23:0] SFR_O_EROPC = 24'h000031;
  localparam logic [23:0] SFR_O_RDCAP = 24'h000032;
  localparam logic [23:0] SFR_O_RDPAD = 24'h000033;
  localparam logic [23:0] SFR_O_DEN0 = 24'h000034;
  localparam logic [23:0] SFR_O_DEN1 = 24'h000035;
  localparam logic [23:0] SFR_O_DEN2 = 24'h000036;
  localparam logic [23:0] SFR_O_DEN3 = 24'h000037;
  localparam logic [23:0] SFR_O_Q4WT = 24'h000038;
  localparam logic [23:0] SFR_O_Q4OPC = 24'h000039;
  localparam logic [23:0] SFR_O_Q1WT = 24'h00003A;
  localparam logic [23:0] SFR_O_Q1OPC = 24'h00003B;
  localparam logic [23:0] SFR_O_D1WT = 24'h00003C;
  localparam logic [23:0] SFR_O_D1OPC = 24'h00003D;
  // ----------------------------------------------------------------
  // byte values
  // ----------------------------------------------------------------
  localparam logic [7:0] SFR_V_SIG0 = 8'h53;
  localparam logic [7:0] SFR_V_SIG1 = 8'h46;
  localparam logic [7:0] SFR_V_SIG2 = 8'h44;
  localparam logic [7:0] SFR_V_SIG3 = 8'h50;
  localparam logic [7:0] SFR_V_REV_MIN = 8'h00;
  localparam logic [7:0] SFR_V_REV_MAJ = 8'h01;
  localparam logic [7:0] SFR_V_NHDR = 8'h01;
  localparam logic [7:0] SFR_V_STD_ID = 8'h00;
  localparam logic [7:0] SFR_V_H0LEN = 8'h09;
  localparam logic [7:0] SFR_V_H0P0 = 8'h30;
  localparam logic [7:0] SFR_V_PTR_HI = 8'h00;
  localparam logic [7:0] SFR_V_H1LEN = 8'h03;
  localparam logic [7:0] SFR_V_H1P0 = 8'h60;
  // erase config byte: [7:5] unused, [4] opc sel, [3] vol, [2] gran, [1:0]
  localparam logic [2:0] SFR_F_ER_PAD = 3'h7;
  localparam logic [0:0] SFR_F_WE_SEL = 1'h0;
  localparam logic [0:0] SFR_F_VOLAT = 1'h0;
  localparam logic [0:0] SFR_F_GRAN64 = 1'h1;
  localparam logic [1:0] SFR_F_ER4K = 2'h1;
  localparam logic [7:0] SFR_V_EROPC = 8'h20;
  // read caps byte: [7] pad, [6] 1-1-4, [5] 1-4-4, [4] 1-2-2, [3] dtr,
  // [2:1] address bytes, [0] 1-1-2
  localparam logic [0:0] SFR_F_RD_PAD = 1'h1;
  localparam logic [0:0] SFR_F_Q114 = 1'h1;
  localparam logic [0:0] SFR_F_Q144 = 1'h1;
  localparam logic [0:0] SFR_F_D122 = 1'h1;
  localparam logic [0:0] SFR_F_DTR = 1'h0;
  localparam logic [1:0] SFR_F_ADDR3 = 2'h0;
  localparam logic [0:0] SFR_F_D112 = 1'h1;
  localparam logic [7:0] SFR_V_DEN0 = 8'hFF;
  localparam logic [7:0] SFR_V_DEN1 = 8'hFF;
  localparam logic [7:0] SFR_V_DEN2 = 8'h7F;
  localparam logic [7:0] SFR_V_DEN3 = 8'h00;
  // wait byte: [7:5] mode bits, [4:0] wait states
  localparam logic [2:0] SFR_F_Q4MODE = 3'h2;
  localparam logic [4:0] SFR_F_Q4WAIT = 5'h04;
  localparam logic [7:0] SFR_V_Q4OPC = 8'hEB;
  localparam logic [2:0] SFR_F_Q1MODE = 3'h0;
  localparam logic [4:0] SFR_F_Q1WAIT = 5'h08;
  localparam logic [7:0] SFR_V_Q1OPC = 8'h6B;
  localparam logic [2:0] SFR_F_D1MODE = 3'h0;
  localparam logic [4:0] SFR_F_D1WAIT = 5'h08;
  localparam logic [7:0] SFR_V_D1OPC = 8'h3B;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SFR_S_OPC = 3'b000,
    SFR_S_ADDR = 3'b001,
    SFR_S_DUMMY = 3'b010,
    SFR_S_DATA = 3'b011,
    SFR_S_SKIP = 3'b100
  } sfr_state_t;
endpackage : sfr_pkg

/* File: rtl/sfr_rom.sv */
// read-only parameter byte store with registered read data
`timescale 1ns/1ps
module sfr_rom
  import sfr_pkg::*;
#(
  parameter logic [7:0] VENDOR_ID = 8'hA5 // arbitrary neutral value
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic rd_en_i,
  input wire logic [SFR_OFS_W-1:0] rd_addr_i,
  output logic [7:0] rd_data_o
);
  logic [7:0] rom_byte;

  // ----------------------------------------------------------------
  // content
  // ----------------------------------------------------------------
  // constant table only: nothing can write it, so reads repeat exactly
  always_comb begin // see [R22]
    case (rd_addr_i)
      SFR_O_SIG0: rom_byte = SFR_V_SIG0; // see [R01]
      SFR_O_SIG1: rom_byte = SFR_V_SIG1; // see [R01]
      SFR_O_SIG2: rom_byte = SFR_V_SIG2; // see [R01]
      SFR_O_SIG3: rom_byte = SFR_V_SIG3; // see [R01]
      SFR_O_MINOR: rom_byte = SFR_V_REV_MIN; // see [R01]
      SFR_O_MAJOR: rom_byte = SFR_V_REV_MAJ; // see [R02]
      SFR_O_NHDR: rom_byte = SFR_V_NHDR; // see [R03]
      SFR_O_H0ID: rom_byte = SFR_V_STD_ID; // see [R05]
      SFR_O_H0MIN: rom_byte = SFR_V_REV_MIN; // see [R05]
      SFR_O_H0MAJ: rom_byte = SFR_V_REV_MAJ; // see [R05]
      SFR_O_H0LEN: rom_byte = SFR_V_H0LEN; // see [R06]
      SFR_O_H0P0: rom_byte = SFR_V_H0P0; // see [R07]
      SFR_O_H0P1: rom_byte = SFR_V_PTR_HI; // see [R07]
      SFR_O_H0P2: rom_byte = SFR_V_PTR_HI; // see [R07]
      SFR_O_H1ID: rom_byte = VENDOR_ID; // see [R08]
      SFR_O_H1MIN: rom_byte = SFR_V_REV_MIN; // see [R08]
      SFR_O_H1MAJ: rom_byte = SFR_V_REV_MAJ; // see [R08]
      SFR_O_H1LEN: rom_byte = SFR_V_H1LEN; // see [R09]
      SFR_O_H1P0: rom_byte = SFR_V_H1P0; // see [R09]
      SFR_O_H1P1: rom_byte = SFR_V_PTR_HI; // see [R09]
      SFR_O_H1P2: rom_byte = SFR_V_PTR_HI; // see [R09]
      SFR_O_ERCFG: rom_byte = {SFR_F_ER_PAD, SFR_F_WE_SEL, SFR_F_VOLAT,
        SFR_F_GRAN64, SFR_F_ER4K}; // see [R10] [R11] [R12] [R13]
      SFR_O_EROPC: rom_byte = SFR_V_EROPC; // see [R10]
      SFR_O_RDCAP: rom_byte = {SFR_F_RD_PAD, SFR_F_Q114, SFR_F_Q144,
        SFR_F_D122, SFR_F_DTR, SFR_F_ADDR3, SFR_F_D112}; // see [R14] [R15]
      SFR_O_DEN0: rom_byte = SFR_V_DEN0;
      SFR_O_DEN1: rom_byte = SFR_V_DEN1;
      SFR_O_DEN2: rom_byte = SFR_V_DEN2;
      SFR_O_DEN3: rom_byte = SFR_V_DEN3;
      SFR_O_Q4WT: rom_byte = {SFR_F_Q4MODE, SFR_F_Q4WAIT}; // see [R16]
      SFR_O_Q4OPC: rom_byte = SFR_V_Q4OPC; // see [R16]
      SFR_O_Q1WT: rom_byte = {SFR_F_Q1MODE, SFR_F_Q1WAIT}; // see [R17]
      SFR_O_Q1OPC: rom_byte = SFR_V_Q1OPC; // see [R17]
      SFR_O_D1WT: rom_byte = {SFR_F_D1MODE, SFR_F_D1WAIT}; // see [R18]
      SFR_O_D1OPC: rom_byte = SFR_V_D1OPC; // see [R21]
      // pads 07H/0FH/17H/33H and everything unpopulated read as fill
      default: rom_byte = SFR_FILL; // see [R04]
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_data_o <= SFR_FILL;
    end else if (rd_en_i) begin
      rd_data_o <= rom_byte;
    end
  end
endmodule : sfr_rom

/* File: rtl/sfr_top.sv */
// discoverable-parameter read sequencer over a byte-wide serial front end
`timescale 1ns/1ps
module sfr_top
  import sfr_pkg::*;
#(
  parameter logic [7:0] VENDOR_ID = 8'hA5 // arbitrary neutral value
) (
  input wire logic CORE_CLK_I,
  input wire logic RSTN_I,
  input wire logic SEL_N_I,
  input wire logic RX_VALID_I,
  input wire logic [7:0] RX_BYTE_I,
  input wire logic TX_REQ_I,
  output logic TX_VALID_O,
  output logic [7:0] TX_BYTE_O,
  output logic ACTIVE_O,
  output logic [SFR_OFS_W-1:0] OFFSET_O
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sfr_state_t state_reg;
  sfr_state_t state_next;
  logic [1:0] addr_cnt_reg;
  logic [SFR_OFS_W-1:0] ofs_reg;
  logic tx_valid_reg;
  logic rd_fire;
  logic rx_fire;

  assign rx_fire = RX_VALID_I && !SEL_N_I;
  // a request outside the data phase is simply dropped, no answer
  assign rd_fire = TX_REQ_I && !SEL_N_I && (state_reg == SFR_S_DATA);

  // ----------------------------------------------------------------
  // command sequencing
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SFR_S_OPC: begin
        if (rx_fire) begin
          // any other opcode, write and erase included, never reaches
          // the table; it just waits out the frame
          if (RX_BYTE_I == SFR_OPC_READ) begin
            state_next = SFR_S_ADDR;
          end else begin
            state_next = SFR_S_SKIP; // see [R22]
          end
        end
      end
      SFR_S_ADDR: begin
        if (rx_fire && addr_cnt_reg == SFR_ADDR_LAST) begin
          state_next = SFR_S_DUMMY; // see [R23]
        end
      end
      SFR_S_DUMMY: begin
        if (rx_fire) begin
          state_next = SFR_S_DATA;
        end
      end
      SFR_S_DATA: state_next = SFR_S_DATA;
      SFR_S_SKIP: state_next = SFR_S_SKIP;
      default: state_next = SFR_S_OPC;
    endcase
    if (SEL_N_I) begin
      state_next = SFR_S_OPC; // see [R23]
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_reg <= SFR_S_OPC;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // address capture and increment
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      addr_cnt_reg <= 2'h0;
    end else if (SEL_N_I || state_reg != SFR_S_ADDR) begin
      addr_cnt_reg <= 2'h0;
    end else if (rx_fire) begin
      addr_cnt_reg <= addr_cnt_reg + 2'h1;
    end
  end

  // offset arrives high byte first; wraps at the 24-bit limit
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ofs_reg <= SFR_OFS_ZERO;
    end else if (rx_fire && state_reg == SFR_S_ADDR) begin
      ofs_reg <= {ofs_reg[SFR_OFS_W-9:0], RX_BYTE_I}; // see [R23]
    end else if (rd_fire) begin
      ofs_reg <= ofs_reg + SFR_OFS_ONE; // see [R23]
    end
  end

  // ----------------------------------------------------------------
  // table and answer
  // ----------------------------------------------------------------
  sfr_rom #(
    .VENDOR_ID(VENDOR_ID)
  ) u_rom (
    .clk_i(CORE_CLK_I),
    .rstn_i(RSTN_I),
    .rd_en_i(rd_fire),
    .rd_addr_i(ofs_reg),
    .rd_data_o(TX_BYTE_O)
  );

  // answer follows the request by one edge; dropped on deselect
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      tx_valid_reg <= 1'b0;
    end else begin
      tx_valid_reg <= rd_fire;
    end
  end

  assign TX_VALID_O = tx_valid_reg;
  assign ACTIVE_O = (state_reg == SFR_S_DATA);
  assign OFFSET_O = ofs_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RSTN_I);

  sequence s_read(logic [SFR_OFS_W-1:0] ofs);
    rd_fire && ofs_reg == ofs;
  endsequence

  property p_byte(logic [SFR_OFS_W-1:0] ofs, logic [7:0] val);
    s_read(ofs) |=> TX_VALID_O && TX_BYTE_O == val;
  endproperty

  sequence s_enter;
    SEL_N_I ##1 rx_fire && RX_BYTE_I == SFR_OPC_READ;
  endsequence

  chk_sig_first: assert property (p_byte(SFR_O_SIG0, 8'h53)) // see [R01]
    else $error("signature byte 0 wrong");
  chk_sig_last: assert property (p_byte(SFR_O_SIG3, 8'h50)) // see [R01]
    else $error("signature byte 3 wrong");
  chk_major_rev: assert property (p_byte(SFR_O_MAJOR, 8'h01)) // see [R02]
    else $error("major revision wrong");
  chk_hdr_count: assert property (p_byte(SFR_O_NHDR, 8'h01)) // see [R03]
    else $error("header count wrong");
  chk_pad_bytes: assert property ( // see [R04]
    (rd_fire && (ofs_reg == SFR_O_PAD0 || ofs_reg == SFR_O_PAD1 ||
      ofs_reg == SFR_O_PAD2)) |=> TX_BYTE_O == 8'hFF)
    else $error("unused byte not FFH");
  chk_std_id: assert property (p_byte(SFR_O_H0ID, 8'h00)) // see [R05]
    else $error("standard header id wrong");
  chk_std_len: assert property (p_byte(SFR_O_H0LEN, 8'h09)) // see [R06]
    else $error("standard table length wrong");
  chk_std_ptr: assert property (p_byte(SFR_O_H0P0, 8'h30)) // see [R07]
    else $error("standard table pointer wrong");
  chk_vnd_id: assert property (p_byte(SFR_O_H1ID, VENDOR_ID)) // see [R08]
    else $error("vendor header id wrong");
  chk_vnd_ptr: assert property (p_byte(SFR_O_H1P0, 8'h60)) // see [R09]
    else $error("vendor table pointer wrong");
  chk_erase_cfg: assert property (p_byte(SFR_O_ERCFG, 8'hE5)) // see [R13]
    else $error("erase config byte wrong");
  chk_erase_opc: assert property (p_byte(SFR_O_EROPC, 8'h20)) // see [R10]
    else $error("erase opcode wrong");
  chk_gran_bits: assert property ( // see [R11] [R12]
    s_read(SFR_O_ERCFG) |=> TX_BYTE_O[4:2] == 3'h1)
    else $error("granularity or volatile bits wrong");
  chk_addr_mode: assert property ( // see [R14]
    s_read(SFR_O_RDCAP) |=> TX_BYTE_O[2:1] == 2'h0)
    else $error("address width field wrong");
  chk_read_caps: assert property (p_byte(SFR_O_RDCAP, 8'hF1)) // see [R15]
    else $error("read capability byte wrong");
  chk_quad_io: assert property (p_byte(SFR_O_Q4WT, 8'h44)) // see [R16]
    else $error("quad io wait byte wrong");
  chk_quad_opc: assert property (p_byte(SFR_O_Q4OPC, 8'hEB)) // see [R16]
    else $error("quad io opcode wrong");
  chk_quad_out: assert property (p_byte(SFR_O_Q1WT, 8'h08)) // see [R17]
    else $error("quad output wait byte wrong");
  chk_qout_opc: assert property (p_byte(SFR_O_Q1OPC, 8'h6B)) // see [R17]
    else $error("quad output opcode wrong");
  chk_dual_out: assert property (p_byte(SFR_O_D1WT, 8'h08)) // see [R18]
    else $error("dual output wait byte wrong");
  chk_dual_opc: assert property (p_byte(SFR_O_D1OPC, 8'h3B)) // see [R21]
    else $error("dual output opcode wrong");
  // helper flag: frame opened with a foreign opcode, held until deselect
  logic chk_foreign_reg;
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      chk_foreign_reg <= 1'b0;
    end else if (SEL_N_I) begin
      chk_foreign_reg <= 1'b0;
    end else if (rx_fire && state_reg == SFR_S_OPC &&
        RX_BYTE_I != SFR_OPC_READ) begin
      chk_foreign_reg <= 1'b1;
    end
  end

  chk_other_cmd: assert property ( // see [R22]
    chk_foreign_reg |-> !ACTIVE_O)
    else $error("foreign command reached data phase");
  chk_offset_inc: assert property ( // see [R23]
    rd_fire |=> OFFSET_O == $past(OFFSET_O) + SFR_OFS_ONE)
    else $error("offset did not advance");
  chk_frame_ends: assert property ( // see [R23]
    SEL_N_I |=> !ACTIVE_O && !TX_VALID_O ##1 !ACTIVE_O)
    else $error("deselect did not end the read");
  chk_data_phase: assert property ( // see [R23]
    s_enter ##1 (rx_fire [*4]) |=> ACTIVE_O)
    else $error("read did not reach data phase");
endmodule : sfr_top

/* File: bench/sfr_host_model.sv */
// host controller model issuing discoverable-parameter read frames
`timescale 1ns/1ps
module sfr_host_model (
  input wire logic clk_i,
  output logic sel_n_o,
  output logic rx_valid_o,
  output logic [7:0] rx_byte_o,
  output logic tx_req_o,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic active_i,
  input wire logic [23:0] offset_i
);
  logic [7:0] got_q[$];
  logic [23:0] last_ofs;
  logic act_seen;
  initial begin
    sel_n_o = 1'b1;
    rx_valid_o = 1'b0;
    rx_byte_o = 8'h00;
    tx_req_o = 1'b0;
  end
  // ----------------------------------------------------------------
  // wait byte decode
  // ----------------------------------------------------------------
  function automatic logic dummy_ok(input logic [7:0] b);
    return b[4:0] != 5'h00;
  endfunction : dummy_ok
  function automatic logic mode_ok(input logic [7:0] b);
    return b[7:5] != 3'h0;
  endfunction : mode_ok
  // ----------------------------------------------------------------
  // one frame: header bytes, then n reads spaced by gap idle cycles
  // ----------------------------------------------------------------
  task automatic read_frame(input logic [7:0] opc, input logic [23:0] ofs,
                            input int nhdr, input int n, input int gap);
    logic [7:0] hdr[5];
    int issued;
    int cyc;
    hdr = '{opc, ofs[23:16], ofs[15:8], ofs[7:0], 8'h00};
    got_q.delete();
    act_seen = 1'b0;
    issued = 0;
    cyc = 0;
    @(posedge clk_i);
    sel_n_o <= 1'b0;
    for (int i = 0; i < nhdr; i++) begin
      rx_valid_o <= 1'b1;
      rx_byte_o <= hdr[i];
      @(posedge clk_i);
    end
    rx_valid_o <= 1'b0;
    // released line shows no stale value
    rx_byte_o <= ~hdr[nhdr-1];
    while (got_q.size() < n && cyc < n * (gap + 1) + 6) begin
      if (issued < n && cyc % (gap + 1) == 0) begin
        tx_req_o <= 1'b1;
        issued++;
      end else begin
        tx_req_o <= 1'b0;
      end
      // look between edges, where the answer has settled
      @(negedge clk_i);
      if (tx_valid_i === 1'b1) begin
        got_q.push_back(tx_byte_i);
      end
      act_seen = act_seen | (active_i === 1'b1);
      last_ofs = offset_i;
      @(posedge clk_i);
      cyc++;
    end
    sel_n_o <= 1'b1;
    tx_req_o <= 1'b0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask : read_frame
endmodule : sfr_host_model

/* File: bench/sfr_top_test.sv */
// self-checking bench for the parameter read block
`timescale 1ns/1ps
module sfr_top_test;
  import sfr_pkg::*;
  localparam logic [7:0] TB_VENDOR = 8'h3C; // arbitrary neutral value
  logic core_clk;
  logic rstn;
  logic sel_n;
  logic rx_valid;
  logic [7:0] rx_byte;
  logic tx_req;
  logic tx_valid;
  logic [7:0] tx_byte;
  logic active;
  logic [23:0] offset;
  int mismatches = 0;
  int compares = 0;
  sfr_top #(.VENDOR_ID(TB_VENDOR)) u_dut (
    .CORE_CLK_I(core_clk),
    .RSTN_I(rstn),
    .SEL_N_I(sel_n),
    .RX_VALID_I(rx_valid),
    .RX_BYTE_I(rx_byte),
    .TX_REQ_I(tx_req),
    .TX_VALID_O(tx_valid),
    .TX_BYTE_O(tx_byte),
    .ACTIVE_O(active),
    .OFFSET_O(offset)
  );
  sfr_host_model u_host (
    .clk_i(core_clk),
    .sel_n_o(sel_n),
    .rx_valid_o(rx_valid),
    .rx_byte_o(rx_byte),
    .tx_req_o(tx_req),
    .tx_valid_i(tx_valid),
    .tx_byte_i(tx_byte),
    .active_i(active),
    .offset_i(offset)
  );
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // ----------------------------------------------------------------
  // expected table content
  // ----------------------------------------------------------------
  function automatic logic [7:0] exp_byte(input logic [23:0] a);
    case (a)
      24'h000000: return 8'h53;
      24'h000001: return 8'h46;
      24'h000002: return 8'h44;
      24'h000003: return 8'h50;
      24'h000004: return 8'h00;
      24'h000005: return 8'h01;
      24'h000006: return 8'h01;
      24'h000008, 24'h000009: return 8'h00;
      24'h00000A: return 8'h01;
      24'h00000B: return 8'h09;
      24'h00000C: return 8'h30;
      24'h00000D, 24'h00000E: return 8'h00;
      24'h000010: return TB_VENDOR;
      24'h000011: return 8'h00;
      24'h000012: return 8'h01;
      24'h000013: return 8'h03;
      24'h000014: return 8'h60;
      24'h000015, 24'h000016: return 8'h00;
      24'h000030: return {3'b111, 2'b00, 1'b1, 2'b01};
      24'h000031: return 8'h20;
      24'h000032: return {4'b1111, 1'b0, 2'b00, 1'b1};
      24'h000036: return 8'h7F;
      24'h000037: return 8'h00;
      24'h000038: return {3'b010, 5'b00100};
      24'h000039: return 8'hEB;
      24'h00003A: return {3'b000, 5'b01000};
      24'h00003B: return 8'h6B;
      24'h00003C: return {3'b000, 5'b01000};
      24'h00003D: return 8'h3B;
      default: return 8'hFF;
    endcase
  endfunction : exp_byte
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic run_read(input logic [23:0] ofs, input int n,
                          input int gap);
    u_host.read_frame(SFR_OPC_READ, ofs, 5, n, gap);
    check("byte count", 32'(u_host.got_q.size()), 32'(n));
    for (int i = 0; i < u_host.got_q.size(); i++) begin
      check("table byte", 32'(u_host.got_q[i]),
            32'(exp_byte(24'(ofs + 24'(i)))));
    end
    check("end offset", 32'(u_host.last_ofs),
          32'(24'(ofs + 24'(n))));
    check("active seen", 32'(u_host.act_seen), 32'h1);
    check("active after deselect", 32'(active), 32'h0);
  endtask : run_read
  task automatic refused(input logic [7:0] opc, input int nhdr);
    u_host.read_frame(opc, 24'h000030, nhdr, 3, 0);
    check("refused count", 32'(u_host.got_q.size()), 32'h0);
    check("refused active", 32'(u_host.act_seen), 32'h0);
  endtask : refused
  task automatic pulse_reset;
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
  endtask : pulse_reset
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    run_read(24'h000000, 64, 0);
    $display("test full table done");
    run_read(24'hFFFFFE, 4, 0);
    $display("test offset wrap done");
    refused(8'h03, 5);
    refused(SFR_OPC_READ, 3);
    run_read(24'h00000F, 2, 0);
    $display("test refused frames done");
    pulse_reset();
    run_read(24'h000030, 14, 2);
    check("dummy decode", 32'(u_host.dummy_ok(u_host.got_q[12])),
          32'h1);
    check("mode decode", 32'(u_host.mode_ok(u_host.got_q[12])),
          32'h0);
    $display("test slow host after reset done");
    give_verdict();
  end
  // budget well above the few hundred cycles the tests need
  initial begin
    #(20000 * 5);
    mismatches++;
    $display("ERROR watchdog expected done seen hang");
    give_verdict();
  end
endmodule : sfr_top_test
